// >>> verilog/swtc_defines.svh
// Register offsets, reset values and limits of the sweep and time_measure_group parameter block
//////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - Sweep minimum current accepted from 0 to 105% of current range; read back.
// - Sweep start frequency accepted 0 to 50 kHz in hertz; read back.
// - Sweep end frequency accepted 0 to 50 kHz in hertz; read back.
// - Sweep point count accepted 0 to 5000; read back as integer.
// - Stepping method stored, logarithmic or linear; query gives 0 for logarithmic.
// - Sweep dwell accepted 0 to 99.999 s, 1 ms resolution; read back.
// - Sweep duty accepted as whole percent 2 to 99; read back.
// - Four time_measure_group modes stored; query answers the mode keyword, not a code.
// - Time_measure_group current setpoint limited to 105% of current range; unit optional.
// - Time_measure_group voltage setpoint limited to 105% of voltage range; unit optional.
// - Time_measure_group power setpoint stored in watts and read back.
// - Time_measure_group resistance setpoint stored in ohms and read back.
// - Host pairs start/end selector with source; source kept per start and end.
// - Source query answers start,end pair with code 0 for trigger.
// - Host pairs start/end selector with edge; edge kept per start and end.
// - Edge query answers start,end pair with code 1 for rising.
// - Every query returns the stored value without altering it.
`ifndef SWTC_DEFINES_SVH
`define SWTC_DEFINES_SVH

// Byte offsets of the word registers
`define SWTC_OFS_SWP_IMIN   8'h00
`define SWTC_OFS_SWP_FSTART 8'h04
`define SWTC_OFS_SWP_FEND   8'h08
`define SWTC_OFS_SWP_POINTS 8'h0C
`define SWTC_OFS_SWP_STEP   8'h10
`define SWTC_OFS_SWP_DWELL  8'h14
`define SWTC_OFS_SWP_DUTY   8'h18
`define SWTC_OFS_TM_MODE    8'h1C
`define SWTC_OFS_TM_CURR    8'h20
`define SWTC_OFS_TM_VOLT    8'h24
`define SWTC_OFS_TM_POWER   8'h28
`define SWTC_OFS_TM_RES     8'h2C
`define SWTC_OFS_TM_SIG     8'h30
`define SWTC_OFS_TM_EDGE    8'h34
`define SWTC_OFS_I_RANGE    8'h38
`define SWTC_OFS_V_RANGE    8'h3C
`define SWTC_OFS_STATUS     8'h40

// Limits
`define SWTC_FREQ_MAX_HZ    32'h0000_C350
`define SWTC_POINTS_MAX     32'h0000_1388
`define SWTC_DWELL_MAX_MS   32'h0001_869F
`define SWTC_DUTY_MIN       32'h0000_0002
`define SWTC_DUTY_MAX       32'h0000_0063
`define SWTC_PCT_LIMIT      40'h00_0000_0069
`define SWTC_PCT_FULL       40'h00_0000_0064

// Reset values
`define SWTC_RST_ZERO       32'h0000_0000
`define SWTC_RST_DUTY       32'h0000_0002

// Answer characters
`define SWTC_ASCII_ZERO     8'h30
`define SWTC_ASCII_COMMA    8'h2C
`define SWTC_KEY_CONST_CURR  16'h4343
`define SWTC_KEY_CONST_VOLT  16'h4356
`define SWTC_KEY_CONST_POWER 16'h4350
`define SWTC_KEY_CONST_RES   16'h4352

`endif

// >>> verilog/swtc_pkg.sv
// Types shared by the sweep and time_measure_group parameter block
package swtc_pkg;
    typedef enum logic [1:0] {
        SWTC_MODE_CONST_CURR,
        SWTC_MODE_CONST_VOLT,
        SWTC_MODE_CONST_POWER,
        SWTC_MODE_CONST_RES
    } swtc_mode_t;

    typedef enum logic [1:0] {
        SWTC_SRC_TRIG,
        SWTC_SRC_VOLT,
        SWTC_SRC_CURR
    } swtc_src_t;
endpackage : swtc_pkg

// >>> verilog/swtc_top.sv
// Sweep and time measurement parameter store behind an Avalon-MM slave
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "swtc_defines.svh"

module swtc_top
    import swtc_pkg::*;
#(
    parameter logic [31:0] I_FULL_SCALE_MA = 32'h0000_7530,
    parameter logic [31:0] V_FULL_SCALE_MV = 32'h0001_D4C0
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    output logic             reject_o
);

    // Elaboration check: a zero full scale would refuse every nonzero current or voltage setpoint
    if (I_FULL_SCALE_MA == 32'h0000_0000 || V_FULL_SCALE_MV == 32'h0000_0000) begin : g_bad_scale
        $error("full scale defaults must be nonzero");
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Stored settings
    logic [31:0] swp_imin_ff;
    logic [31:0] swp_fstart_ff;
    logic [31:0] swp_fend_ff;
    logic [31:0] swp_points_ff;
    logic        swp_step_lin_ff;
    logic [31:0] swp_dwell_ff;
    logic [31:0] swp_duty_ff;
    swtc_mode_t  tm_mode_ff;
    logic [31:0] tm_curr_ff;
    logic [31:0] tm_volt_ff;
    logic [31:0] tm_power_ff;
    logic [31:0] tm_res_ff;
    swtc_src_t   src_start_ff;
    swtc_src_t   src_end_ff;
    logic        edge_start_rise_ff;
    logic        edge_end_rise_ff;
    logic [31:0] i_range_ff;
    logic [31:0] v_range_ff;
    logic        reject_ff;
    logic        waitrequest_ff;
    logic [31:0] readdata_ff;

    logic        acc_wr;
    logic        bad_val;
    logic        known;
    logic        full_word;
    logic [39:0] wd_pct;
    logic [39:0] i_lim;
    logic [39:0] v_lim;
    logic [31:0] nxt_readdata;
    logic [15:0] mode_key;

    //////////////////////////////////////////////////////////////////////////////////////
    // Handshake: one wait cycle, write commits at the edge waitrequest is seen low
    assign acc_wr    = write_i && !waitrequest_ff;
    assign full_word = (byteenable_i == 4'hF);
    assign wd_pct    = {8'h00, writedata_i} * `SWTC_PCT_FULL;
    assign i_lim     = {8'h00, i_range_ff} * `SWTC_PCT_LIMIT;
    assign v_lim     = {8'h00, v_range_ff} * `SWTC_PCT_LIMIT;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            waitrequest_ff <= 1'b1;
        end else if ((read_i || write_i) && waitrequest_ff) begin
            waitrequest_ff <= 1'b0;
        end else begin
            waitrequest_ff <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Range check of the value offered with a write
    always_comb begin
        known   = 1'b1;
        bad_val = 1'b0;
        unique case (address_i)
            `SWTC_OFS_SWP_IMIN:   bad_val = wd_pct > i_lim;
            `SWTC_OFS_SWP_FSTART: bad_val = writedata_i > `SWTC_FREQ_MAX_HZ;
            `SWTC_OFS_SWP_FEND:   bad_val = writedata_i > `SWTC_FREQ_MAX_HZ;
            `SWTC_OFS_SWP_POINTS: bad_val = writedata_i > `SWTC_POINTS_MAX;
            `SWTC_OFS_SWP_STEP:   bad_val = writedata_i[31:1] != 31'h0;
            `SWTC_OFS_SWP_DWELL:  bad_val = writedata_i > `SWTC_DWELL_MAX_MS;
            `SWTC_OFS_SWP_DUTY:   bad_val = writedata_i < `SWTC_DUTY_MIN
                                         || writedata_i > `SWTC_DUTY_MAX;
            `SWTC_OFS_TM_MODE:    bad_val = writedata_i[31:2] != 30'h0;
            `SWTC_OFS_TM_CURR:    bad_val = wd_pct > i_lim;
            `SWTC_OFS_TM_VOLT:    bad_val = wd_pct > v_lim;
            `SWTC_OFS_TM_POWER:   bad_val = 1'b0;
            `SWTC_OFS_TM_RES:     bad_val = 1'b0;
            `SWTC_OFS_TM_SIG:     bad_val = writedata_i[31:3] != 29'h0
                                         || writedata_i[2:1] == 2'b11;
            `SWTC_OFS_TM_EDGE:    bad_val = writedata_i[31:2] != 30'h0;
            `SWTC_OFS_I_RANGE:    bad_val = writedata_i == 32'h0000_0000;
            `SWTC_OFS_V_RANGE:    bad_val = writedata_i == 32'h0000_0000;
            `SWTC_OFS_STATUS:     bad_val = 1'b0;
            default:              known   = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Sweep settings; a rejected value leaves the old one in place
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            swp_imin_ff     <= `SWTC_RST_ZERO;
            swp_fstart_ff   <= `SWTC_RST_ZERO;
            swp_fend_ff     <= `SWTC_RST_ZERO;
            swp_points_ff   <= `SWTC_RST_ZERO;
            swp_step_lin_ff <= 1'b0;
            swp_dwell_ff    <= `SWTC_RST_ZERO;
            swp_duty_ff     <= `SWTC_RST_DUTY;
        end else if (acc_wr && full_word && !bad_val) begin
            unique case (address_i)
                `SWTC_OFS_SWP_IMIN:   swp_imin_ff     <= writedata_i;
                `SWTC_OFS_SWP_FSTART: swp_fstart_ff   <= writedata_i;
                `SWTC_OFS_SWP_FEND:   swp_fend_ff     <= writedata_i;
                `SWTC_OFS_SWP_POINTS: swp_points_ff   <= writedata_i;
                `SWTC_OFS_SWP_STEP:   swp_step_lin_ff <= writedata_i[0];
                `SWTC_OFS_SWP_DWELL:  swp_dwell_ff    <= writedata_i;
                `SWTC_OFS_SWP_DUTY:   swp_duty_ff     <= writedata_i;
                default: ;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Time measurement settings and full scale ranges
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tm_mode_ff         <= SWTC_MODE_CONST_CURR;
            tm_curr_ff         <= `SWTC_RST_ZERO;
            tm_volt_ff         <= `SWTC_RST_ZERO;
            tm_power_ff        <= `SWTC_RST_ZERO;
            tm_res_ff          <= `SWTC_RST_ZERO;
            src_start_ff       <= SWTC_SRC_TRIG;
            src_end_ff         <= SWTC_SRC_TRIG;
            edge_start_rise_ff <= 1'b1;
            edge_end_rise_ff   <= 1'b1;
            i_range_ff         <= I_FULL_SCALE_MA;
            v_range_ff         <= V_FULL_SCALE_MV;
        end else if (acc_wr && full_word && !bad_val) begin
            unique case (address_i)
                `SWTC_OFS_TM_MODE:  tm_mode_ff  <= swtc_mode_t'(writedata_i[1:0]);
                `SWTC_OFS_TM_CURR:  tm_curr_ff  <= writedata_i;
                `SWTC_OFS_TM_VOLT:  tm_volt_ff  <= writedata_i;
                `SWTC_OFS_TM_POWER: tm_power_ff <= writedata_i;
                `SWTC_OFS_TM_RES:   tm_res_ff   <= writedata_i;
                `SWTC_OFS_TM_SIG: begin
                    // Selector bit 0 picks start or end
                    if (writedata_i[0]) begin
                        src_end_ff <= swtc_src_t'(writedata_i[2:1]);
                    end else begin
                        src_start_ff <= swtc_src_t'(writedata_i[2:1]);
                    end
                end
                `SWTC_OFS_TM_EDGE: begin
                    if (writedata_i[0]) begin
                        edge_end_rise_ff <= writedata_i[1];
                    end else begin
                        edge_start_rise_ff <= writedata_i[1];
                    end
                end
                `SWTC_OFS_I_RANGE: i_range_ff <= writedata_i;
                `SWTC_OFS_V_RANGE: v_range_ff <= writedata_i;
                default: ;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Sticky reject flag; a new rejection wins over a write-one clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reject_ff <= 1'b0;
        end else if (acc_wr && known && (bad_val || !full_word)) begin
            reject_ff <= 1'b1;
        end else if (acc_wr && address_i == `SWTC_OFS_STATUS && writedata_i[0]) begin
            reject_ff <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Query answers; reading never changes a setting
    always_comb begin
        unique case (tm_mode_ff)
            SWTC_MODE_CONST_CURR:  mode_key = `SWTC_KEY_CONST_CURR;
            SWTC_MODE_CONST_VOLT:  mode_key = `SWTC_KEY_CONST_VOLT;
            SWTC_MODE_CONST_POWER: mode_key = `SWTC_KEY_CONST_POWER;
            SWTC_MODE_CONST_RES:   mode_key = `SWTC_KEY_CONST_RES;
        endcase
    end

    always_comb begin
        nxt_readdata = 32'h0000_0000;
        unique case (address_i)
            `SWTC_OFS_SWP_IMIN:   nxt_readdata = swp_imin_ff;
            `SWTC_OFS_SWP_FSTART: nxt_readdata = swp_fstart_ff;
            `SWTC_OFS_SWP_FEND:   nxt_readdata = swp_fend_ff;
            `SWTC_OFS_SWP_POINTS: nxt_readdata = swp_points_ff;
            `SWTC_OFS_SWP_STEP:   nxt_readdata = {31'h0, swp_step_lin_ff};
            `SWTC_OFS_SWP_DWELL:  nxt_readdata = swp_dwell_ff;
            `SWTC_OFS_SWP_DUTY:   nxt_readdata = swp_duty_ff;
            `SWTC_OFS_TM_MODE:    nxt_readdata = {16'h0000, mode_key};
            `SWTC_OFS_TM_CURR:    nxt_readdata = tm_curr_ff;
            `SWTC_OFS_TM_VOLT:    nxt_readdata = tm_volt_ff;
            `SWTC_OFS_TM_POWER:   nxt_readdata = tm_power_ff;
            `SWTC_OFS_TM_RES:     nxt_readdata = tm_res_ff;
            `SWTC_OFS_TM_SIG:     nxt_readdata = {8'h00,
                                      `SWTC_ASCII_ZERO + {6'h00, src_start_ff},
                                      `SWTC_ASCII_COMMA,
                                      `SWTC_ASCII_ZERO + {6'h00, src_end_ff}};
            `SWTC_OFS_TM_EDGE:    nxt_readdata = {8'h00,
                                      `SWTC_ASCII_ZERO + {7'h00, edge_start_rise_ff},
                                      `SWTC_ASCII_COMMA,
                                      `SWTC_ASCII_ZERO + {7'h00, edge_end_rise_ff}};
            `SWTC_OFS_I_RANGE:    nxt_readdata = i_range_ff;
            `SWTC_OFS_V_RANGE:    nxt_readdata = v_range_ff;
            `SWTC_OFS_STATUS:     nxt_readdata = {31'h0, reject_ff};
            default:              nxt_readdata = 32'h0000_0000;
        endcase
    end

    // Read data captured in the wait cycle, held until the next read
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_ff <= 32'h0000_0000;
        end else if (read_i && waitrequest_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    assign readdata_o    = readdata_ff;
    assign waitrequest_o = waitrequest_ff;
    assign reject_o      = reject_ff;

endmodule : swtc_top

// >>> bench/swtc_top_asserts.sv
// Port-level checker for the sweep and time_measure_group parameter block
`timescale 1ns/1ps
`include "swtc_defines.svh"
module swtc_top_asserts (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0]  byteenable_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic        reject_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic ans;
    ////////////////////////////////////////////////////////////////////////////////
    // Request and query answer qualifiers
    assign req = read_i || write_i;
    assign ans = read_i && !waitrequest_o;
    ////////////////////////////////////////////////////////////////////////////////
    chk_wait_answer: assert property (req && waitrequest_o |=> !waitrequest_o)
        else $error("transfer not answered after one wait cycle");
    chk_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    chk_wait_cause: assert property (!waitrequest_o |-> $past(req))
        else $error("answer without a request");
    chk_rdata_hold: assert property (!$past(read_i) |-> $stable(readdata_o))
        else $error("read data changed without a query");
    chk_reject_hold: assert property (reject_o && !(write_i && address_i == `SWTC_OFS_STATUS)
        |=> reject_o)
        else $error("reject flag dropped without a clear");
    chk_reject_cause: assert property ($rose(reject_o) |-> $past(write_i && !waitrequest_o))
        else $error("reject flag rose without a committed write");
    chk_step_code: assert property (ans && address_i == `SWTC_OFS_SWP_STEP
        |-> readdata_o[31:1] == 31'h0000_0000)
        else $error("stepping query not a one-bit code");
    chk_mode_key: assert property (ans && address_i == `SWTC_OFS_TM_MODE
        |-> readdata_o[31:8] == 24'h00_0043
        && readdata_o[7:0] inside {8'h43, 8'h56, 8'h50, 8'h52})
        else $error("mode query not a keyword");
    chk_duty_range: assert property (ans && address_i == `SWTC_OFS_SWP_DUTY
        |-> readdata_o inside {[32'h0000_0002:32'h0000_0063]})
        else $error("stored duty out of range");
    chk_pair_comma: assert property (ans && address_i inside {`SWTC_OFS_TM_SIG, `SWTC_OFS_TM_EDGE}
        |-> readdata_o[31:24] == 8'h00 && readdata_o[15:8] == 8'h2C)
        else $error("pair answer lacks the separator");
    chk_freq_max: assert property (ans && address_i inside {`SWTC_OFS_SWP_FSTART, `SWTC_OFS_SWP_FEND}
        |-> readdata_o <= 32'h0000_C350)
        else $error("stored frequency above limit");
endmodule : swtc_top_asserts

bind swtc_top swtc_top_asserts u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .reject_o(reject_o));

// >>> bench/swtc_host.sv
// Avalon-MM host model issuing set and query transfers
`timescale 1ns/1ps
module swtc_host (
    input  wire logic        core_clk_i,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i,
    output logic [7:0]       address_o,
    output logic             read_o,
    output logic             write_o,
    output logic [31:0]      writedata_o,
    output logic [3:0]       byteenable_o
);
    // Idle bus at time zero
    initial begin
        address_o    = 8'h00;
        read_o       = 1'b0;
        write_o      = 1'b0;
        writedata_o  = 32'h0000_0000;
        byteenable_o = 4'hF;
    end
    // One transfer, held until waitrequest is sampled low
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        @(posedge core_clk_i);
        address_o    <= a;
        writedata_o  <= d;
        byteenable_o <= be;
        read_o       <= rd;
        write_o      <= ~rd;
        do @(posedge core_clk_i); while (waitrequest_i !== 1'b0);
        q = readdata_i;
        // Released address and data lines show the inverse of the last value; read and write drop low
        read_o       <= 1'b0;
        write_o      <= 1'b0;
        address_o    <= ~a;
        writedata_o  <= ~d;
    endtask : xfer
endmodule : swtc_host

// >>> bench/tb_top.sv
// Self-checking bench for the sweep and time_measure_group parameter block
`timescale 1ns/1ps
module tb_top;
    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic [31:0] q;
    logic [31:0] v;
    logic [3:0]  byteenable;
    logic        waitreq;
    logic        reject;
    int          err_count = 0;
    int          tests_run = 0;
    localparam logic [7:0]  LA[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h20, 8'h24};
    localparam logic [31:0] LM[7] = '{32'h0000_7B0C, 32'h0000_C350, 32'h0000_C350,
        32'h0000_1388, 32'h0001_869F, 32'h0000_7B0C, 32'h0001_EC30};
    localparam logic [7:0]  MK[4] = '{8'h43, 8'h56, 8'h50, 8'h52};
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #10 core_clk_i = ~core_clk_i;
    swtc_host u_host (.core_clk_i(core_clk_i), .readdata_i(readdata), .waitrequest_i(waitreq),
        .address_o(address), .read_o(read), .write_o(write), .writedata_o(writedata),
        .byteenable_o(byteenable));
    swtc_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .address_i(address),
        .read_i(read), .write_i(write), .writedata_i(writedata), .byteenable_i(byteenable),
        .readdata_o(readdata), .waitrequest_o(waitreq), .reject_o(reject));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare, bus shorthands, reporting
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b0, a, d, 4'hF, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        u_host.xfer(1'b1, a, 32'h0000_0000, 4'hF, q);
        cmp(q, e);
    endtask : rdc
    // Expected ASCII start,end answer of a pair query
    function automatic logic [31:0] pair_exp(input int st, input int en);
        return {8'h00, 8'(8'h30 + st), 8'h2C, 8'(8'h30 + en)};
    endfunction : pair_exp
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // Watchdog
    initial begin
        #(20 * 20000);
        $display("watchdog expired");
        err_count++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h0000_594F));
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rdc(8'h18, 32'h0000_0002);
        rdc(8'h1C, 32'h0000_4343);
        rdc(8'h30, 32'h0030_2C30);
        rdc(8'h34, 32'h0031_2C31);
        rdc(8'h10, 32'h0000_0000);
        wr(8'h44, 32'hFFFF_FFFF);
        rdc(8'h44, 32'h0000_0000);
        rdc(8'h40, 32'h0000_0000);
        tend("reset");
        // Random in-range values, the top value, one past it
        for (int i = 0; i < 7; i++) begin
            for (int n = 0; n < 3; n++) begin
                v = $urandom_range(LM[i]);
                wr(LA[i], v);
                rdc(LA[i], v);
                rdc(LA[i], v);
            end
            wr(LA[i], LM[i]);
            wr(LA[i], LM[i] + 32'h0000_0001);
            rdc(LA[i], LM[i]);
            rdc(8'h40, 32'h0000_0001);
            cmp({31'h0, reject}, 32'h0000_0001);
            wr(8'h40, 32'h0000_0001);
            rdc(8'h40, 32'h0000_0000);
        end
        tend("limits");
        wr(8'h18, 32'h0000_0063);
        wr(8'h18, 32'h0000_0001);
        rdc(8'h18, 32'h0000_0063);
        wr(8'h18, 32'h0000_0064);
        wr(8'h18, 32'h0000_0002);
        u_host.xfer(1'b0, 8'h18, 32'h0000_0010, 4'h3, q);
        rdc(8'h18, 32'h0000_0002);
        wr(8'h10, 32'h0000_0001);
        wr(8'h10, 32'h0000_0002);
        rdc(8'h10, 32'h0000_0001);
        wr(8'h10, 32'h0000_0000);
        rdc(8'h10, 32'h0000_0000);
        tend("duty step");
        for (int m = 3; m >= 0; m--) begin
            wr(8'h1C, 32'(m));
            rdc(8'h1C, {16'h0000, 8'h43, MK[m]});
        end
        for (int n = 0; n < 4; n++) begin
            v = $urandom();
            wr(8'h28 + 8'(4 * (n % 2)), v);
            rdc(8'h28 + 8'(4 * (n % 2)), v);
        end
        tend("modes");
        // Host pairs a selector with a source, end first then start
        for (int s = 0; s < 3; s++) begin
            wr(8'h30, {29'h0, s[1:0], 1'b1});
            wr(8'h30, {29'h0, 2'(2 - s), 1'b0});
            rdc(8'h30, pair_exp(2 - s, s));
        end
        wr(8'h30, 32'h0000_0006);
        rdc(8'h30, 32'h0030_2C32);
        wr(8'h34, 32'h0000_0000);
        rdc(8'h34, 32'h0030_2C31);
        wr(8'h34, 32'h0000_0001);
        rdc(8'h34, 32'h0030_2C30);
        wr(8'h34, 32'h0000_0002);
        rdc(8'h34, 32'h0031_2C30);
        tend("signals");
        // Range registers scale the 105% limits; zero range is refused
        wr(8'h38, 32'h0000_03E8);
        wr(8'h20, 32'h0000_041A);
        wr(8'h20, 32'h0000_041B);
        rdc(8'h20, 32'h0000_041A);
        wr(8'h3C, 32'h0000_07D0);
        wr(8'h24, 32'h0000_0834);
        wr(8'h24, 32'h0000_0835);
        rdc(8'h24, 32'h0000_0834);
        wr(8'h38, 32'h0000_0000);
        rdc(8'h38, 32'h0000_03E8);
        tend("ranges");
        // Mid-run reset brings back the reset settings
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rdc(8'h38, 32'h0000_7530);
        rdc(8'h34, 32'h0031_2C31);
        rdc(8'h30, pair_exp(0, 0));
        rdc(8'h40, 32'h0000_0000);
        tend("reset again");
        end_of_test();
    end
endmodule : tb_top
